// ---- rx_cfg_pkg.sv ----
// Purpose: shared constants and carriers for the receiver config block
// Assumes: AHB-Lite word registers, byte address = index * 4
// Notes: analog sensing is outside; pins arrive as comparator levels
package rx_cfg_pkg;
  // register indices
  localparam logic [7:0] IDX_VOUT_SEL = 8'h08;
  localparam logic [7:0] IDX_VOUT_STAT = 8'h09;
  localparam logic [7:0] IDX_THERM_SET = 8'h0c;
  localparam logic [7:0] IDX_THERM_STAT = 8'h0d;
  localparam logic [7:0] IDX_ALIGN_EN = 8'h21;
  localparam logic [7:0] IDX_ALIGN_RATIO = 8'h24;
  localparam logic [7:0] IDX_QPKT_CTRL = 8'h37;
  localparam logic [7:0] IDX_QPKT_VAL = 8'h3a;
  // reset values
  localparam logic [7:0] RST_VOUT_SEL = 8'h01;
  localparam logic [7:0] RST_THERM_SET = 8'h44;
  localparam logic [7:0] RST_ALIGN_EN = 8'h00;
  localparam logic [7:0] RST_ALIGN_RATIO = 8'h00;
  localparam logic [7:0] RST_QPKT_CTRL = 8'h41;
  localparam logic [7:0] RST_QPKT_VAL = 8'h00;
  // field positions
  localparam int VOUT_OVR_BIT = 7;
  localparam int QPKT_SRC_BIT = 6;
  localparam int QPKT_SEND_BIT = 0;
  localparam int THERM_EN_BIT = 6;
  localparam int ALIGN_EN_BIT = 0;
  localparam int ALIGN_FLAG_BIT = 1;
  // timing
  localparam int CLK_HZ = 10000000;
  localparam int MISALIGN_DELAY_MS = 30;
  localparam int MISALIGN_CYCLES = CLK_HZ / 1000 * MISALIGN_DELAY_MS;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // pin inputs from the analog side
  typedef struct packed {
    logic rectified_rail_undervoltage; // rectifier uv active
    logic rail_below_thresh; // rectified rail under misalign threshold
    logic alt_standard; // 1 = alternate standard mode
    logic strap_short; // strap pin to ground
    logic strap_open; // strap pin open
    logic strap_in_range; // strap adc reading valid
    logic [2:0] strap_code; // strap decoded voltage code
    logic therm_above; // thermistor pin above trip voltage
    logic ctrl_eoc; // external end-of-charge request
    logic charge_ended; // charging completed
    logic ping_seen; // ping received on coil
    logic timer_node_high; // removal timing node still charged
  } pins_in_t;
  // controls toward packet logic and analog
  typedef struct packed {
    logic quality_packet_send_en;
    logic quality_source_select;
    logic [7:0] coil_quality_value;
    logic [2:0] vout_effective;
    logic [3:0] misalign_threshold_ratio;
    logic [3:0] thermistor_threshold;
    logic end_of_charge;
    logic end_power_transfer_packet;
    logic no_charge_signal;
    logic removal_recharge;
  } ctl_out_t;
endpackage : rx_cfg_pkg

// ---- rx_config_strap_monitor.sv ----
// Purpose: register bank, strap decode, misalign check, thermistor, pad removal
// Assumes: one 10 MHz clock, synchronous active-high reset, AHB-Lite slave
// Notes: strap state is captured once after reset and then held
// Summary of operation
// - send enable bit sends quality packet
// - quality taken from value register
// - quality byte sent unchanged
// - rail below threshold raises interrupt
// - misalign check off until enabled
// - check evaluated 30ms after undervoltage release
// - threshold ratio code drives comparator reference
// - register used on override or open strap
// - voltage select code passed to regulator
// - strap short sends fault or no-charge
// - status shows short, decoded, applied voltage
// - status bit 3 shows open strap
// - alternate mode overtemp sends end-of-charge
// - no overtemp detection in primary mode
// - thermistor enable bit gates detection
// - threshold code drives trip reference
// - thermistor status shows overtemp flag
// - control pin sends end-of-charge
// - ping recharges node, removal output low
// - node discharge releases removal output
// - interrupt output active low, edge events
`timescale 1ns/1ps
module rx_config_strap_monitor #(
  parameter int MISALIGN_WAIT = rx_cfg_pkg::MISALIGN_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire rx_cfg_pkg::pins_in_t pins,
  output rx_cfg_pkg::ctl_out_t ctl,
  output logic irq_n,
  output logic pad_removed_out,
  output logic pad_removed_oe
);
  import rx_cfg_pkg::*;

  // register storage, defined fields only
  // one flop per documented bit keeps the reserved bits out of storage
  logic vout_ovr_ff;
  logic [2:0] vout_select_ff;
  logic therm_en_ff;
  logic [3:0] therm_th_ff;
  logic align_en_ff;
  logic [3:0] align_ratio_ff;
  logic qsrc_ff;
  logic qsend_ff;
  logic [7:0] qval_ff;
  // interrupt flag visible in the alignment enable register
  logic misalign_flag_ff;
  // bus data phase capture
  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic [7:0] rd_byte;
  // synchronised pins
  pins_in_t sync1_ff;
  pins_in_t sync2_ff;
  logic uv_prev_ff;
  // captured strap state
  logic strap_short_ff;
  logic strap_open_ff;
  logic [2:0] strap_dec_ff;
  logic [1:0] settle_ff;
  // misalign timer
  // wide enough for the full start-up delay at 10 MHz
  logic [31:0] wait_cnt_ff;
  logic misalign_hit;
  logic [2:0] vout_eff;
  logic overtemp;
  // outputs
  ctl_out_t ctl_ff;
  logic [7:0] rdata_ff;

  typedef enum logic [1:0] {
    STRAP_WAIT = 2'b01,
    STRAP_HELD = 2'b10
  } strap_st_t;
  strap_st_t strap_st_ff;

  typedef enum logic [2:0] {
    MIS_IDLE = 3'b001,
    MIS_COUNT = 3'b010,
    MIS_DONE = 3'b100
  } mis_st_t;
  mis_st_t mis_st_ff;

  // address phase decode
  // a_idx is the word index; byte lanes below bit 2 are ignored
  wire logic take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire logic [7:0] a_idx = haddr[9:2];

  // two-stage synchroniser for every pin
  // every analog comparator level is asynchronous to clk
  always_ff @(posedge clk) begin
    if (reset) begin
      // undervoltage resets to its power-up level, so no false release follows reset
      sync1_ff <= '{rectified_rail_undervoltage: 1'b1, default: '0};
      sync2_ff <= '{rectified_rail_undervoltage: 1'b1, default: '0};
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  // write capture in address phase
  // hwdata only arrives one cycle later, so the target index is kept for it
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= take & hwrite;
      wr_idx_ff <= a_idx;
    end
  end

  // register writes in the data phase
  // reserved bits are not stored and read back as zero
  always_ff @(posedge clk) begin
    if (reset) begin
      vout_ovr_ff <= RST_VOUT_SEL[VOUT_OVR_BIT];
      vout_select_ff <= RST_VOUT_SEL[2:0];
      therm_en_ff <= RST_THERM_SET[THERM_EN_BIT];
      therm_th_ff <= RST_THERM_SET[3:0];
      align_en_ff <= RST_ALIGN_EN[ALIGN_EN_BIT];
      align_ratio_ff <= RST_ALIGN_RATIO[3:0];
      qsrc_ff <= RST_QPKT_CTRL[QPKT_SRC_BIT];
      qsend_ff <= RST_QPKT_CTRL[QPKT_SEND_BIT];
      qval_ff <= RST_QPKT_VAL;
    end else if (wr_pend_ff) begin
      if (wr_idx_ff == IDX_VOUT_SEL) begin
        vout_ovr_ff <= hwdata[VOUT_OVR_BIT];
        vout_select_ff <= hwdata[2:0];
      end else if (wr_idx_ff == IDX_THERM_SET) begin
        therm_en_ff <= hwdata[THERM_EN_BIT];
        therm_th_ff <= hwdata[3:0];
      end else if (wr_idx_ff == IDX_ALIGN_EN) begin
        // enable only by writing bit 0
        align_en_ff <= hwdata[ALIGN_EN_BIT];
      end else if (wr_idx_ff == IDX_ALIGN_RATIO) begin
        align_ratio_ff <= hwdata[3:0];
      end else if (wr_idx_ff == IDX_QPKT_CTRL) begin
        qsrc_ff <= hwdata[QPKT_SRC_BIT];
        qsend_ff <= hwdata[QPKT_SEND_BIT];
      end else if (wr_idx_ff == IDX_QPKT_VAL) begin
        qval_ff <= hwdata[7:0];
      end
    end
  end

  // strap capture once after reset, after the synchroniser has filled
  // the strap is a board setting, so one sample after power-up is enough;
  // holding it stops a noisy divider from moving the output voltage later
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_st_ff <= STRAP_WAIT;
      settle_ff <= 2'h0;
      strap_short_ff <= 1'b0;
      strap_open_ff <= 1'b0;
      strap_dec_ff <= 3'h0;
    end else begin
      case (strap_st_ff)
        STRAP_WAIT: begin
          settle_ff <= settle_ff + 2'h1;
          if (settle_ff == STRAP_SETTLE) begin
            strap_short_ff <= sync2_ff.strap_short;
            strap_open_ff <= sync2_ff.strap_open;
            // decoded value zero when out of range
            strap_dec_ff <= sync2_ff.strap_in_range ? sync2_ff.strap_code : 3'h0;
            strap_st_ff <= STRAP_HELD;
          end
        end
        STRAP_HELD: begin
          strap_st_ff <= STRAP_HELD;
        end
        default: begin
          strap_st_ff <= STRAP_WAIT;
        end
      endcase
    end
  end

  // register wins on override or open strap
  // an open strap leaves no valid reading, so the register must decide
  always_comb begin
    if (vout_ovr_ff | strap_open_ff) begin
      vout_eff = vout_select_ff;
    end else begin
      vout_eff = strap_dec_ff;
    end
  end

  // overtemp only in alternate mode, gated by enable
  // live level: it clears as soon as the pin falls back
  assign overtemp = sync2_ff.alt_standard & therm_en_ff & sync2_ff.therm_above;

  // undervoltage edge history
  // starts high so that a rail already up at reset still counts as a start-up
  always_ff @(posedge clk) begin
    if (reset) begin
      uv_prev_ff <= 1'b1;
    end else begin
      uv_prev_ff <= sync2_ff.rectified_rail_undervoltage;
    end
  end

  // wait after undervoltage release, then evaluate once
  // any undervoltage during the wait restarts the whole start-up
  always_ff @(posedge clk) begin
    if (reset) begin
      mis_st_ff <= MIS_IDLE;
      wait_cnt_ff <= 32'h0;
    end else if (sync2_ff.rectified_rail_undervoltage) begin
      // rail lost: rearm for the next start-up
      mis_st_ff <= MIS_IDLE;
      wait_cnt_ff <= 32'h0;
    end else begin
      case (mis_st_ff)
        MIS_IDLE: begin
          if (uv_prev_ff) begin
            mis_st_ff <= MIS_COUNT;
            wait_cnt_ff <= 32'h0;
          end
        end
        MIS_COUNT: begin
          wait_cnt_ff <= wait_cnt_ff + 32'h1;
          if (wait_cnt_ff == 32'(MISALIGN_WAIT - 1)) begin
            mis_st_ff <= MIS_DONE;
          end
        end
        MIS_DONE: begin
          mis_st_ff <= MIS_DONE;
        end
        default: begin
          mis_st_ff <= MIS_IDLE;
        end
      endcase
    end
  end

  // one-cycle event at the end of the wait when rail is low
  // evaluated exactly once, at the last count of the wait
  assign misalign_hit = (mis_st_ff == MIS_COUNT) & (wait_cnt_ff == 32'(MISALIGN_WAIT - 1))
                        & align_en_ff & sync2_ff.rail_below_thresh;

  // sticky flag, write 1 to clear, a new event wins
  // set beats clear so that an event in the clearing cycle is never lost
  always_ff @(posedge clk) begin
    if (reset) begin
      misalign_flag_ff <= 1'b0;
    end else if (misalign_hit) begin
      misalign_flag_ff <= 1'b1;
    end else if (wr_pend_ff & (wr_idx_ff == IDX_ALIGN_EN) & hwdata[ALIGN_FLAG_BIT]) begin
      misalign_flag_ff <= 1'b0;
    end
  end

  // active-low interrupt from the flag
  // the hit term makes the pin fall in the same cycle as the flag sets
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(misalign_flag_ff | misalign_hit);
    end
  end

  // read mux for the address phase
  // unmapped indices read zero; hsize is ignored since every access is a word
  always_comb begin
    rd_byte = 8'h00;
    if (a_idx == IDX_VOUT_SEL) begin
      rd_byte = {vout_ovr_ff, 4'h0, vout_select_ff};
    end else if (a_idx == IDX_VOUT_STAT) begin
      rd_byte = {strap_short_ff, strap_dec_ff, strap_open_ff, vout_eff};
    end else if (a_idx == IDX_THERM_SET) begin
      rd_byte = {1'b0, therm_en_ff, 2'h0, therm_th_ff};
    end else if (a_idx == IDX_THERM_STAT) begin
      rd_byte = {7'h00, overtemp};
    end else if (a_idx == IDX_ALIGN_EN) begin
      rd_byte = {6'h00, misalign_flag_ff, align_en_ff};
    end else if (a_idx == IDX_ALIGN_RATIO) begin
      rd_byte = {4'h0, align_ratio_ff};
    end else if (a_idx == IDX_QPKT_CTRL) begin
      rd_byte = {1'b0, qsrc_ff, 5'h00, qsend_ff};
    end else if (a_idx == IDX_QPKT_VAL) begin
      rd_byte = qval_ff;
    end
  end

  // read data registered for the data phase
  // the value stays until the next read so a slow master still sees it
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (take & ~hwrite) begin
      rdata_ff <= rd_byte;
    end
  end

  // bus answer: zero wait, always okay
  // kept as flops so that every bus output comes straight from a register
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = {24'h000000, rdata_ff};

  // control outputs toward packet logic and analog
  // one register stage keeps the outputs glitch-free toward the analog side
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_ff <= '0;
    end else begin
      ctl_ff.quality_packet_send_en <= qsend_ff;
      ctl_ff.quality_source_select <= qsrc_ff;
      ctl_ff.coil_quality_value <= qval_ff;
      ctl_ff.vout_effective <= vout_eff;
      ctl_ff.misalign_threshold_ratio <= align_ratio_ff;
      ctl_ff.thermistor_threshold <= therm_th_ff;
      // overtemp and control pin end charge
      ctl_ff.end_of_charge <= overtemp | sync2_ff.ctrl_eoc;
      // short gives fault or no-charge by mode
      ctl_ff.end_power_transfer_packet <= strap_short_ff & ~sync2_ff.alt_standard;
      ctl_ff.no_charge_signal <= strap_short_ff & sync2_ff.alt_standard;
      // ping after charging recharges the node
      ctl_ff.removal_recharge <= sync2_ff.charge_ended & sync2_ff.ping_seen;
    end
  end
  assign ctl = ctl_ff;

  // hold removal low while node charged, release on discharge
  // open drain: the data bit stays low and only the enable moves;
  // the board pull-up makes the high level once the node has discharged
  always_ff @(posedge clk) begin
    if (reset) begin
      pad_removed_oe <= 1'b0;
      pad_removed_out <= 1'b0;
    end else begin
      pad_removed_oe <= sync2_ff.charge_ended & sync2_ff.timer_node_high;
      pad_removed_out <= 1'b0;
    end
  end
endmodule : rx_config_strap_monitor

// ---- rx_cfg_checker_assertions.sv ----
// Purpose: port checks for the receiver config block
// Assumes: pin levels reach ctl three edges after they are sampled
// Notes: up_ff hides edges whose history still reaches into reset
`timescale 1ns/1ps
module rx_cfg_checker #(
  parameter int MISALIGN_WAIT = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire rx_cfg_pkg::pins_in_t pins,
  input wire rx_cfg_pkg::ctl_out_t ctl,
  input wire logic irq_n,
  input wire logic pad_removed_out,
  input wire logic pad_removed_oe
);
  import rx_cfg_pkg::*;
  logic [2:0] up_ff; // edges since reset release, saturating
  logic [31:0] low_ff; // length of the undervoltage-low run
  // count history since release
  always_ff @(posedge clk) begin
    if (reset) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  // count cycles with the rail out of undervoltage
  always_ff @(posedge clk) begin
    if (reset || pins.rectified_rail_undervoltage) low_ff <= 16'h0;
    else if (low_ff != 32'hffffffff) low_ff <= low_ff + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_eoc_ctrl;
    up_ff > 3'h3 && $past(pins.ctrl_eoc, 3) |-> ctl.end_of_charge;
  endproperty
  a_eoc_ctrl: assert property (p_eoc_ctrl) else $error("end of charge missing");
  property p_eoc_primary;
    up_ff > 3'h3 && !$past(pins.alt_standard, 3) && !$past(pins.ctrl_eoc, 3)
      |-> !ctl.end_of_charge;
  endproperty
  a_eoc_primary: assert property (p_eoc_primary) else $error("overtemp in primary");
  property p_recharge;
    up_ff > 3'h3 |->
      ctl.removal_recharge == ($past(pins.charge_ended, 3) && $past(pins.ping_seen, 3));
  endproperty
  a_recharge: assert property (p_recharge) else $error("recharge level wrong");
  property p_pad_oe;
    up_ff > 3'h3 |->
      pad_removed_oe == ($past(pins.charge_ended, 3) && $past(pins.timer_node_high, 3));
  endproperty
  a_pad_oe: assert property (p_pad_oe) else $error("removal pin enable wrong");
  property p_pad_low;
    pad_removed_oe |-> !pad_removed_out;
  endproperty
  a_pad_low: assert property (p_pad_low) else $error("removal pin driven high");
  property p_irq_delay;
    $fell(irq_n) |-> low_ff >= MISALIGN_WAIT && low_ff <= MISALIGN_WAIT + 8;
  endproperty
  a_irq_delay: assert property (p_irq_delay) else $error("misalign irq off time");
  property p_ept_mode;
    up_ff > 3'h3 && ctl.end_power_transfer_packet |-> !$past(pins.alt_standard, 3);
  endproperty
  a_ept_mode: assert property (p_ept_mode) else $error("fault packet in alt mode");
  property p_nocharge_mode;
    up_ff > 3'h3 && ctl.no_charge_signal |-> $past(pins.alt_standard, 3);
  endproperty
  a_nocharge_mode: assert property (p_nocharge_mode) else $error("no-charge wrong mode");
endmodule : rx_cfg_checker

bind rx_config_strap_monitor rx_cfg_checker #(.MISALIGN_WAIT(MISALIGN_WAIT)) u_chk (
  .clk(clk), .reset(reset), .pins(pins), .ctl(ctl), .irq_n(irq_n),
  .pad_removed_out(pad_removed_out), .pad_removed_oe(pad_removed_oe));

// ---- rx_host_model.sv ----
// Purpose: host side of the pad removal pin
// Assumes: the host board pulls the removal pin up
// Notes: counts rising edges as host firmware would
`timescale 1ns/1ps
module rx_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic pad_removed_out,
  input wire logic pad_removed_oe,
  output logic pad_level,
  output logic [3:0] removals
);
  logic last_ff; // pin level at the previous edge
  // released pin goes to the pull-up level
  assign pad_level = pad_removed_oe ? pad_removed_out : 1'b1;
  always_ff @(posedge clk) begin
    if (reset) begin
      last_ff <= 1'b1;
      removals <= 4'h0;
    end else begin
      last_ff <= pad_level;
      if (pad_level && !last_ff) removals <= removals + 4'h1;
    end
  end
endmodule : rx_host_model

// ---- testbench.sv ----
// Purpose: self-checking bench for the receiver config block
// Assumes: zero-wait bus slave, pins seen three edges later
// Notes: misalign delay shortened to WAIT cycles
`timescale 1ns/1ps
module testbench;
  import rx_cfg_pkg::*;
  localparam int WAIT = 20; // shortened misalign delay
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, irq_n, pad_removed_out, pad_removed_oe, pad_level;
  logic [31:0] hrdata;
  pins_in_t pins;
  ctl_out_t ctl;
  logic [3:0] removals, e;
  logic [7:0] rd, v;
  logic [2:0] code;
  logic [7:0] ridx [8] = '{IDX_VOUT_SEL, IDX_THERM_SET, IDX_ALIGN_EN, IDX_ALIGN_RATIO,
    IDX_QPKT_CTRL, IDX_QPKT_VAL, IDX_THERM_STAT, 8'h50};
  logic [7:0] rrst [8] = '{8'h01, 8'h44, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00};
  logic [3:0] etab [5] = '{4'h7, 4'h6, 4'h3, 4'h9, 4'hf}; // ctrl, alt, above, enable
  int failures = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  assign hready = hreadyout;
  rx_config_strap_monitor #(.MISALIGN_WAIT(WAIT)) dut (.clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pins, .ctl, .irq_n,
    .pad_removed_out, .pad_removed_oe);
  rx_host_model host (.clk, .reset, .pad_removed_out, .pad_removed_oe, .pad_level, .removals);
  // expected status byte
  function automatic logic [7:0] stat_exp(logic s, logic [2:0] d, logic o, logic [2:0] f);
    return {s, d, o, f};
  endfunction : stat_exp
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    // only the watchdog ends a wait for the slave
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
    chk({7'h0, hresp}, 8'h00);
  endtask : rchk
  task automatic do_reset();
    reset <= 1'b1;
    cyc(8);
    reset <= 1'b0;
    cyc(8);
  endtask : do_reset
  // run one start-up with the check on or off and the rail low or high
  task automatic misalign(input logic en, input logic lo);
    int n;
    logic hit;
    n = 0;
    hit = en & lo;
    pins.rectified_rail_undervoltage <= 1'b1;
    pins.rail_below_thresh <= lo;
    bus(1'b1, IDX_ALIGN_EN, {7'h0, en});
    cyc(4);
    pins.rectified_rail_undervoltage <= 1'b0;
    while (irq_n !== 1'b0 && n < WAIT + 20) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, irq_n}, {7'h0, !hit});
    chk({7'h0, n >= WAIT && n <= WAIT + 8}, {7'h0, hit});
    rchk(IDX_ALIGN_EN, {6'h0, hit, en});
    bus(1'b1, IDX_ALIGN_EN, {6'h0, en, en});
    cyc(3);
    chk({7'h0, irq_n}, 8'h01);
  endtask : misalign
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // watchdog far beyond the expected run
  initial begin
    #(100 * 20000);
    failures++;
    stop_test();
  end
  initial begin
    pins = '0;
    pins.rectified_rail_undervoltage = 1'b1;
    pins.strap_in_range = 1'b1;
    pins.strap_code = 3'h3;
    void'($urandom(12));
    do_reset();
    foreach (ridx[i]) rchk(ridx[i], rrst[i]);
    rchk(IDX_VOUT_STAT, stat_exp(1'b0, 3'h3, 1'b0, 3'h3));
    chk({6'h0, ctl.quality_packet_send_en, ctl.quality_source_select}, 8'h03);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hf0 : (i == 1) ? 8'h0f : 8'($urandom);
      code = (i == 0) ? 3'h7 : (i == 1) ? 3'h1 : 3'($urandom_range(7, 1));
      bus(1'b1, IDX_QPKT_VAL, v);
      bus(1'b1, IDX_ALIGN_RATIO, {4'h0, v[3:0]});
      bus(1'b1, IDX_THERM_SET, {4'h4, v[7:4]});
      bus(1'b1, IDX_VOUT_SEL, {5'h10, code});
      bus(1'b1, IDX_QPKT_CTRL, {1'b0, v[6], 5'h00, v[0]});
      cyc(4);
      chk(ctl.coil_quality_value, v);
      chk({4'h0, ctl.misalign_threshold_ratio}, {4'h0, v[3:0]});
      chk({4'h0, ctl.thermistor_threshold}, {4'h0, v[7:4]});
      chk({5'h0, ctl.vout_effective}, {5'h0, code});
      rchk(IDX_VOUT_STAT, stat_exp(1'b0, 3'h3, 1'b0, code));
      rchk(IDX_QPKT_VAL, v);
      chk({6'h0, ctl.quality_packet_send_en, ctl.quality_source_select}, {6'h0, v[0], v[6]});
      rchk(IDX_QPKT_CTRL, {1'b0, v[6], 5'h00, v[0]});
    end
    bus(1'b1, IDX_VOUT_SEL, 8'h06);
    cyc(4);
    chk({5'h0, ctl.vout_effective}, 8'h03);
    $display("test register fields done");
    foreach (etab[k]) begin
      e = etab[k];
      bus(1'b1, IDX_THERM_SET, {1'b0, e[0], 6'h04});
      pins.ctrl_eoc <= e[3];
      pins.alt_standard <= e[2];
      pins.therm_above <= e[1];
      cyc(5);
      chk({7'h0, ctl.end_of_charge}, {7'h0, e[3] | (e[2] & e[1] & e[0])});
      rchk(IDX_THERM_STAT, {7'h0, e[2] & e[1] & e[0]});
    end
    pins.ctrl_eoc <= 1'b0;
    pins.alt_standard <= 1'b0;
    $display("test end of charge done");
    pins.charge_ended <= 1'b1;
    pins.ping_seen <= 1'b1;
    pins.timer_node_high <= 1'b1;
    cyc(5);
    chk({6'h0, ctl.removal_recharge, pad_level}, 8'h02);
    pins.ping_seen <= 1'b0;
    pins.timer_node_high <= 1'b0;
    cyc(5);
    chk({ctl.removal_recharge, pad_level, 2'h0, removals}, 8'h41);
    $display("test pad removal done");
    misalign(1'b0, 1'b1);
    misalign(1'b1, 1'b0);
    misalign(1'b1, 1'b1);
    $display("test misalign done");
    pins.rectified_rail_undervoltage <= 1'b1;
    pins.strap_short <= 1'b1;
    do_reset();
    rchk(IDX_VOUT_STAT, stat_exp(1'b1, 3'h3, 1'b0, 3'h3));
    chk({6'h0, ctl.end_power_transfer_packet, ctl.no_charge_signal}, 8'h02);
    pins.alt_standard <= 1'b1;
    cyc(5);
    chk({6'h0, ctl.end_power_transfer_packet, ctl.no_charge_signal}, 8'h01);
    pins.alt_standard <= 1'b0;
    pins.strap_short <= 1'b0;
    pins.strap_open <= 1'b1;
    pins.strap_in_range <= 1'b0;
    do_reset();
    rchk(IDX_VOUT_STAT, stat_exp(1'b0, 3'h0, 1'b1, 3'h1));
    pins.strap_open <= 1'b0;
    bus(1'b1, IDX_VOUT_SEL, {5'h0, code});
    cyc(5);
    chk({5'h0, ctl.vout_effective}, {5'h0, code});
    rchk(IDX_VOUT_STAT, stat_exp(1'b0, 3'h0, 1'b1, code));
    $display("test strap states done");
    stop_test();
  end
endmodule : testbench
